// ===== dv/ccu_capture_compare_unit_test.sv
// Purpose: self-checking bench for the capture/compare unit
// Assumes: base timer driven by the bench, pins by the source model
// Notes: the timer is held still around each edge, so a capture value is exact
`timescale 1ns/100ps
module ccu_capture_compare_unit_test;
  logic i_clk, i_rst, i_wr, i_rd, i_adc_enabled, i_ch1_pin, i_ch2_pin;
  logic o_ch1_out, o_ch2_out, o_timer_reset, o_adc_start, o_ch1_irq, o_ch2_irq;
  logic o_ch1_pwm, o_ch2_pwm;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rd;
  logic [15:0] i_base_timer, v;
  logic [9:0] o_ch1_duty, o_ch2_duty;
  logic [1:0] toggle;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_rst, n_adc;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  ccu_capture_compare_unit dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_base_timer, .i_ch1_pin, .i_ch2_pin, .i_adc_enabled, .o_ch1_out, .o_ch2_out,
    .o_timer_reset, .o_adc_start, .o_ch1_irq, .o_ch2_irq, .o_ch1_duty, .o_ch2_duty,
    .o_ch1_pwm, .o_ch2_pwm);
  ccu_pin_source src (.i_clk, .i_rst, .i_toggle(toggle), .o_ch1_pin(i_ch1_pin),
    .o_ch2_pin(i_ch2_pin));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_val({15'h0, got}, {15'h0, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic set_tmr(input logic [15:0] t);
    @(posedge i_clk);
    i_base_timer <= t;
  endtask
  task automatic pin_edge(input int ch);
    @(posedge i_clk);
    toggle[ch] <= 1'b1;
    @(posedge i_clk);
    toggle <= 2'h0;
    repeat (3) @(posedge i_clk);
  endtask
  // two events per run without a read: the second must replace the first
  task automatic cap_run(input int ch, input logic [3:0] mode);
    logic [15:0] hit;
    int n;
    n = (mode == ccu_pkg::MODE_CAP_RISE4) ? 4 : (mode == ccu_pkg::MODE_CAP_RISE16) ? 16 : 1;
    wr(4'(ch * 3), 8'h00);
    wr(4'(ch * 3), {4'h0, mode});
    wr(ccu_pkg::OFF_FLAGS, 8'h00);
    repeat (2) begin
      hit = 16'($urandom);
      for (int i = 0; i < n; i++) begin
        set_tmr((mode != ccu_pkg::MODE_CAP_FALL && i == n - 1) ? hit : ~hit);
        pin_edge(ch);
        set_tmr((mode == ccu_pkg::MODE_CAP_FALL) ? hit : ~hit);
        pin_edge(ch);
      end
    end
    rdr(4'(ch * 3 + 1), rd);
    check_val({8'h0, rd}, {8'h0, hit[7:0]});
    rdr(4'(ch * 3 + 2), rd);
    check_val({8'h0, rd}, {8'h0, hit[15:8]});
    rdr(ccu_pkg::OFF_FLAGS, rd);
    check_bit(rd[ch], 1'b1);
    check_bit(ch ? o_ch2_irq : o_ch1_irq, 1'b1);
  endtask
  task automatic cmp_run(input int ch, input logic [3:0] mode);
    logic [15:0] cv;
    cv = 16'($urandom);
    i_adc_enabled <= 1'($urandom);
    wr(4'(ch * 3), 8'h00);
    wr(4'(ch * 3 + 1), cv[7:0]);
    wr(4'(ch * 3 + 2), cv[15:8]);
    set_tmr(cv - 16'h0005);
    wr(4'(ch * 3), {4'h0, mode});
    wr(ccu_pkg::OFF_FLAGS, 8'h00);
    n_rst = 0;
    n_adc = 0;
    // timer climbs to the value, then rests on it: one match only
    for (int i = 0; i < 12; i++) begin
      @(posedge i_clk);
      i_base_timer <= (i < 3) ? cv - 16'(3 - i) : cv;
      #1 n_rst += (o_timer_reset === 1'b1);
      n_adc += (o_adc_start === 1'b1);
    end
    check_val(16'(n_rst), {15'h0, mode == ccu_pkg::MODE_CMP_TRIG});
    check_val(16'(n_adc), {15'h0, mode == ccu_pkg::MODE_CMP_TRIG && ch == 1 && i_adc_enabled});
    check_bit(ch ? o_ch2_out : o_ch1_out, mode == ccu_pkg::MODE_CMP_SET);
    rdr(ccu_pkg::OFF_FLAGS, rd);
    check_bit(rd[ch], 1'b1);
    wr(4'(ch * 3), 8'h00);
    @(posedge i_clk);
    #1 check_bit(ch ? o_ch2_out : o_ch1_out, 1'b0);
  endtask
  // ----------------------------------------
  // clock, timeout and sequence
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // the full sequence needs well under a fifth of this
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_base_timer = 16'h0000;
    i_adc_enabled = 1'b0;
    toggle = 2'h0;
    void'($urandom(32'hE334));
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rdr(4'(a), rd);
      check_val({8'h0, rd}, 16'h0000);
    end
    for (int a = 0; a < 6; a++) begin
      v = 16'($urandom);
      wr(4'(a), (a % 3 == 0) ? v[7:0] & 8'hF0 : v[7:0]);
      rdr(4'(a), rd);
      check_val({8'h0, rd}, {8'h0, (a % 3 == 0) ? v[7:0] & 8'h30 : v[7:0]});
    end
    wr(4'h9, 8'hFF);
    rdr(4'h9, rd);
    check_val({8'h0, rd}, 16'h0000);
    wr(ccu_pkg::OFF_ENABLES, 8'h03);
    v = 16'($urandom);
    for (int c = 0; c < 2; c++) begin
      wr(4'(c * 3), {2'h0, v[1:0], 4'hC});
      wr(4'(c * 3 + 1), v[9:2]);
    end
    @(posedge i_clk);
    #1 check_val({6'h0, o_ch1_duty}, {6'h0, v[9:0]});
    check_val({6'h0, o_ch2_duty}, {6'h0, v[9:0]});
    check_bit(o_ch1_pwm & o_ch2_pwm, 1'b1);
    rdr(ccu_pkg::OFF_CH1_HIGH, rd);
    wr(ccu_pkg::OFF_CH1_HIGH, ~rd);
    rdr(ccu_pkg::OFF_CH1_HIGH, v[15:8]);
    check_val({8'h0, v[15:8]}, {8'h0, rd});
    for (int c = 0; c < 2; c++) begin
      for (int m = 4; m < 8; m++) cap_run(c, 4'(m));
      for (int m = 8; m < 12; m++) cmp_run(c, 4'(m));
    end
    stop_test();
  end
endmodule

// ===== dv/ccu_pin_source.sv
// Purpose: far-side signal source that drives both channel pins
// Assumes: pins change only just after a rising clock edge
// Notes: the load side is not modelled; the bench watches the compare outputs
`timescale 1ns/100ps
module ccu_pin_source (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_toggle,
  output logic o_ch1_pin,
  output logic o_ch2_pin
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // a synchronous source, so the base timer stays meaningful at each edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ch1_pin <= 1'b0;
      o_ch2_pin <= 1'b0;
    end else begin
      o_ch1_pin <= o_ch1_pin ^ i_toggle[0];
      o_ch2_pin <= o_ch2_pin ^ i_toggle[1];
    end
  end
endmodule

// ===== rtl/ccu_capture_compare_unit.sv
// Purpose: two capture/compare channels, identical but for the trigger effect, sharing a base timer
// Assumes: all inputs synchronous to i_clk; base timer lives outside
// Notes: pwm datapath is external; only its mode code and duty bits are held
//
// Operation
// - value is low and high byte registers
// - both channels identical except trigger effect
// - mode zero disables channel, resets state
// - modes four to seven select capture edges
// - modes eight, nine set/clear pin, flag
// - mode ten only sets flag on match
// - mode eleven flags, resets timer, channel two converts
// - modes 11xx pwm, duty bits exported
// - capture copies whole base timer value
// - capture sets flag, only software clears
// - newer capture silently overwrites older value
// - edges seen from pin level, any direction
// - mode change may flag spuriously
// - prescaler cleared when off or not capturing
// - direct prescaler switch keeps count
// - compare every cycle, act and flag together
// - pwm channels share period timer
// - control write zero forces output latch low
// - trigger resets timer without timer flag
`timescale 1ns/100ps
module ccu_capture_compare_unit #(
  parameter int unsigned TIMER_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [TIMER_W-1:0] i_base_timer,
  input wire logic i_ch1_pin,
  input wire logic i_ch2_pin,
  input wire logic i_adc_enabled,
  output logic o_ch1_out,
  output logic o_ch2_out,
  output logic o_timer_reset,
  output logic o_adc_start,
  output logic o_ch1_irq,
  output logic o_ch2_irq,
  output logic [9:0] o_ch1_duty,
  output logic [9:0] o_ch2_duty,
  output logic o_ch1_pwm,
  output logic o_ch2_pwm
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] low;
    logic [7:0] high;
    logic pin_prev;
    logic [3:0] pre_cnt;
    logic out_latch;
    logic was_equal;
    logic flag;
    logic ien;
  } ccu_chan_t;

  typedef struct packed {
    ccu_chan_t [1:0] ch;
    logic [7:0] rdata;
    logic timer_reset;
    logic adc_start;
    logic [1:0] irq;
    logic [1:0] pwm;
  } ccu_state_t;

  ccu_state_t state_reg;
  ccu_state_t state_next;

  function automatic logic is_capture(input logic [3:0] mode);
    is_capture = (mode[3:2] == 2'b01);
  endfunction

  function automatic logic is_compare(input logic [3:0] mode);
    is_compare = (mode[3:2] == 2'b10);
  endfunction

  logic [1:0] pins;
  assign pins = {i_ch2_pin, i_ch1_pin};

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic [3:0] mode;
    logic rise;
    logic fall;
    logic cap_evt;
    logic equal;
    logic match;
    logic [3:0] coff;
    logic [3:0] loff;
    logic [3:0] hoff;
    logic trig;
    logic conv;
    mode = '0;
    rise = 1'b0;
    fall = 1'b0;
    cap_evt = 1'b0;
    equal = 1'b0;
    match = 1'b0;
    coff = '0;
    loff = '0;
    hoff = '0;
    trig = 1'b0;
    conv = 1'b0;
    state_next = state_reg;
    for (int i = 0; i < 2; i++) begin
      coff = (i == 0) ? ccu_pkg::OFF_CH1_CTRL : ccu_pkg::OFF_CH2_CTRL;
      loff = (i == 0) ? ccu_pkg::OFF_CH1_LOW : ccu_pkg::OFF_CH2_LOW;
      hoff = (i == 0) ? ccu_pkg::OFF_CH1_HIGH : ccu_pkg::OFF_CH2_HIGH;
      mode = state_reg.ch[i].ctrl[ccu_pkg::MODE_LSB +: 4];
      // edges from the pin level whatever its direction
      rise = pins[i] & ~state_reg.ch[i].pin_prev;
      fall = ~pins[i] & state_reg.ch[i].pin_prev;
      state_next.ch[i].pin_prev = pins[i];
      cap_evt = 1'b0;
      unique case (mode)
        ccu_pkg::MODE_CAP_FALL: cap_evt = fall;
        ccu_pkg::MODE_CAP_RISE: cap_evt = rise;
        ccu_pkg::MODE_CAP_RISE4: begin
          cap_evt = rise & (state_reg.ch[i].pre_cnt[1:0] == ccu_pkg::PRE_DIV4_LAST[1:0]);
        end
        ccu_pkg::MODE_CAP_RISE16: begin
          cap_evt = rise & (state_reg.ch[i].pre_cnt == ccu_pkg::PRE_DIV16_LAST);
        end
        default: cap_evt = 1'b0;
      endcase
      // the counter keeps running across a direct prescaler switch
      if (!is_capture(mode)) begin
        state_next.ch[i].pre_cnt = '0;
      end else if (rise) begin
        state_next.ch[i].pre_cnt = state_reg.ch[i].pre_cnt + 4'h1;
      end
      if (cap_evt) begin
        // overwrite with no lockout
        state_next.ch[i].high = i_base_timer[15:8];
        state_next.ch[i].low = i_base_timer[7:0];
      end
      // compare: a held equality fires only once
      equal = ({state_reg.ch[i].high, state_reg.ch[i].low} == i_base_timer[15:0]);
      state_next.ch[i].was_equal = equal & is_compare(mode);
      match = equal & is_compare(mode) & ~state_reg.ch[i].was_equal;
      if (match && mode == ccu_pkg::MODE_CMP_SET) begin
        state_next.ch[i].out_latch = 1'b1;
      end
      if (match && mode == ccu_pkg::MODE_CMP_CLR) begin
        state_next.ch[i].out_latch = 1'b0;
      end
      if (match && mode == ccu_pkg::MODE_CMP_TRIG) begin
        trig = 1'b1;
        if (i == 1) begin
          conv = i_adc_enabled;
        end
      end
      // register writes
      if (i_wr && i_addr == coff) begin
        state_next.ch[i].ctrl = i_wdata & ccu_pkg::CTRL_WMASK;
        if (i_wdata[3:0] == ccu_pkg::MODE_OFF) begin
          state_next.ch[i].out_latch = 1'b0;
          state_next.ch[i].pre_cnt = '0;
          state_next.ch[i].was_equal = 1'b0;
        end
      end
      // in pwm mode the high byte belongs to the pwm datapath
      if (i_wr && i_addr == loff) begin
        state_next.ch[i].low = i_wdata;
      end
      if (i_wr && i_addr == hoff && mode[3:2] != 2'b11) begin
        state_next.ch[i].high = i_wdata;
      end
      if (i_wr && i_addr == ccu_pkg::OFF_ENABLES) begin
        state_next.ch[i].ien = i_wdata[i];
      end
      // a set in the clearing cycle wins; mode changes may flag
      if (i_wr && i_addr == ccu_pkg::OFF_FLAGS && !i_wdata[i]) begin
        state_next.ch[i].flag = 1'b0;
      end
      if (cap_evt || match) begin
        state_next.ch[i].flag = 1'b1;
      end
      state_next.irq[i] = state_next.ch[i].flag & state_next.ch[i].ien;
      // registered so the pwm indication leaves straight from a flop
      state_next.pwm[i] = (state_next.ch[i].ctrl[3:2] == 2'b11);
    end
    state_next.timer_reset = trig;
    state_next.adc_start = conv;
    // read data in the cycle after the strobe
    state_next.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        ccu_pkg::OFF_CH1_CTRL: state_next.rdata = state_reg.ch[0].ctrl;
        ccu_pkg::OFF_CH1_LOW: state_next.rdata = state_reg.ch[0].low;
        ccu_pkg::OFF_CH1_HIGH: state_next.rdata = state_reg.ch[0].high;
        ccu_pkg::OFF_CH2_CTRL: state_next.rdata = state_reg.ch[1].ctrl;
        ccu_pkg::OFF_CH2_LOW: state_next.rdata = state_reg.ch[1].low;
        ccu_pkg::OFF_CH2_HIGH: state_next.rdata = state_reg.ch[1].high;
        ccu_pkg::OFF_FLAGS: state_next.rdata = {6'h00, state_reg.ch[1].flag, state_reg.ch[0].flag};
        ccu_pkg::OFF_ENABLES: state_next.rdata = {6'h00, state_reg.ch[1].ien, state_reg.ch[0].ien};
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_ch1_out = state_reg.ch[0].out_latch;
  assign o_ch2_out = state_reg.ch[1].out_latch;
  assign o_timer_reset = state_reg.timer_reset;
  assign o_adc_start = state_reg.adc_start;
  assign o_ch1_irq = state_reg.irq[0];
  assign o_ch2_irq = state_reg.irq[1];
  // the shared period timer lives outside
  assign o_ch1_duty = {state_reg.ch[0].low, state_reg.ch[0].ctrl[ccu_pkg::DUTY_LSB +: 2]};
  assign o_ch2_duty = {state_reg.ch[1].low, state_reg.ch[1].ctrl[ccu_pkg::DUTY_LSB +: 2]};
  assign o_ch1_pwm = state_reg.pwm[0];
  assign o_ch2_pwm = state_reg.pwm[1];

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_capture_copy;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[0].ctrl[3:0] == ccu_pkg::MODE_CAP_RISE && i_ch1_pin
      && !state_reg.ch[0].pin_prev && !(i_wr && i_addr inside {4'h0, 4'h1, 4'h2}))
    |=> ({state_reg.ch[0].high, state_reg.ch[0].low} == $past(i_base_timer)) && state_reg.ch[0].flag;
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture did not copy timer");

  property p_prescale_clear;
    @(posedge i_clk) disable iff (i_rst)
    !is_capture(state_reg.ch[1].ctrl[3:0]) |=> state_reg.ch[1].pre_cnt == 4'h0;
  endproperty
  a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared");

  property p_off_low;
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == ccu_pkg::OFF_CH1_CTRL && i_wdata == 8'h00) |=> !state_reg.ch[0].out_latch;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output latch not forced low");

  property p_set_on_match;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[0].ctrl[3:0] == ccu_pkg::MODE_CMP_SET && !state_reg.ch[0].was_equal
      && {state_reg.ch[0].high, state_reg.ch[0].low} == i_base_timer && !i_wr)
    |=> state_reg.ch[0].out_latch && state_reg.ch[0].flag ##1 o_ch1_out;
  endproperty
  a_set_on_match: assert property (p_set_on_match) else $error("compare set failed");

  property p_trigger;
    @(posedge i_clk) disable iff (i_rst)
    o_timer_reset |-> $past(state_reg.ch[0].ctrl[3:0] == ccu_pkg::MODE_CMP_TRIG
      || state_reg.ch[1].ctrl[3:0] == ccu_pkg::MODE_CMP_TRIG);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger without trigger mode");

  property p_adc_only_ch2;
    @(posedge i_clk) disable iff (i_rst)
    o_adc_start |-> o_timer_reset && $past(state_reg.ch[1].ctrl[3:0]) == ccu_pkg::MODE_CMP_TRIG;
  endproperty
  a_adc_only_ch2: assert property (p_adc_only_ch2) else $error("conversion from wrong channel");

  property p_flag_sticky;
    @(posedge i_clk) disable iff (i_rst)
    state_reg.ch[0].flag && !(i_wr && i_addr == ccu_pkg::OFF_FLAGS) |=> state_reg.ch[0].flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

  property p_once;
    @(posedge i_clk) disable iff (i_rst)
    state_reg.ch[1].was_equal && is_compare(state_reg.ch[1].ctrl[3:0])
      && state_reg.ch[1].ctrl[3:0] == ccu_pkg::MODE_CMP_TRIG |=> !o_timer_reset || $past(state_reg.ch[0].ctrl[3:0] == ccu_pkg::MODE_CMP_TRIG);
  endproperty
  a_once: assert property (p_once) else $error("match fired twice");

  property p_clr_on_match;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[1].ctrl[3:0] == ccu_pkg::MODE_CMP_CLR && !state_reg.ch[1].was_equal
      && {state_reg.ch[1].high, state_reg.ch[1].low} == i_base_timer && !i_wr)
    |=> !state_reg.ch[1].out_latch && state_reg.ch[1].flag;
  endproperty
  a_clr_on_match: assert property (p_clr_on_match) else $error("compare clear failed");

  property p_soft_keep;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[0].ctrl[3:0] == ccu_pkg::MODE_CMP_SOFT && !i_wr)
    |=> $stable(state_reg.ch[0].out_latch);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft mode moved the pin");

  property p_soft_flag;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[1].ctrl[3:0] == ccu_pkg::MODE_CMP_SOFT && !state_reg.ch[1].was_equal
      && {state_reg.ch[1].high, state_reg.ch[1].low} == i_base_timer)
    |=> state_reg.ch[1].flag;
  endproperty
  a_soft_flag: assert property (p_soft_flag) else $error("soft match did not flag");

  property p_adc_start;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[1].ctrl[3:0] == ccu_pkg::MODE_CMP_TRIG && !state_reg.ch[1].was_equal
      && {state_reg.ch[1].high, state_reg.ch[1].low} == i_base_timer && i_adc_enabled && !i_wr)
    |=> o_adc_start && o_timer_reset;
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("trigger did not start conversion");

  property p_trig_keep;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[1].ctrl[3:0] == ccu_pkg::MODE_CMP_TRIG && !i_wr)
    |=> $stable(state_reg.ch[1].out_latch);
  endproperty
  a_trig_keep: assert property (p_trig_keep) else $error("trigger mode moved the pin");

  property p_fall_capture;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[1].ctrl[3:0] == ccu_pkg::MODE_CAP_FALL && !i_ch2_pin
      && state_reg.ch[1].pin_prev && !(i_wr && i_addr inside {4'h3, 4'h4, 4'h5}))
    |=> ({state_reg.ch[1].high, state_reg.ch[1].low} == $past(i_base_timer)) && state_reg.ch[1].flag;
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("falling capture missed");

  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");

  property p_high_locked;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg.ch[0].ctrl[3:2] == 2'b11 && i_wr && i_addr == ccu_pkg::OFF_CH1_HIGH)
    |=> $stable(state_reg.ch[0].high);
  endproperty
  a_high_locked: assert property (p_high_locked) else $error("high byte written in pwm");

  property p_ch2_off;
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == ccu_pkg::OFF_CH2_CTRL && i_wdata[3:0] == ccu_pkg::MODE_OFF)
    |=> state_reg.ch[1].pre_cnt == 4'h0 && !state_reg.ch[1].was_equal && !o_ch2_out;
  endproperty
  a_ch2_off: assert property (p_ch2_off) else $error("channel off left state");

  property p_irq_level;
    @(posedge i_clk) disable iff (i_rst)
    o_ch2_irq == (state_reg.ch[1].flag && state_reg.ch[1].ien);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("request does not follow flag");

  property p_prescale_hold;
    @(posedge i_clk) disable iff (i_rst)
    (is_capture(state_reg.ch[0].ctrl[3:0]) && !(i_ch1_pin && !state_reg.ch[0].pin_prev)
      && !(i_wr && i_addr == ccu_pkg::OFF_CH1_CTRL))
    |=> $stable(state_reg.ch[0].pre_cnt);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold) else $error("prescaler moved");

  property p_prescale_clear0;
    @(posedge i_clk) disable iff (i_rst)
    !is_capture(state_reg.ch[0].ctrl[3:0]) |=> state_reg.ch[0].pre_cnt == 4'h0;
  endproperty
  a_prescale_clear0: assert property (p_prescale_clear0) else $error("prescaler kept");

endmodule

// ===== rtl/ccu_pkg.sv
// Purpose: constants for the two-channel capture/compare unit
// Assumes: registers reached over a plain strobe port, 8-bit data
// Notes: offsets are register indexes on the local port
package ccu_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_CH1_CTRL = 4'h0;
  localparam logic [3:0] OFF_CH1_LOW = 4'h1;
  localparam logic [3:0] OFF_CH1_HIGH = 4'h2;
  localparam logic [3:0] OFF_CH2_CTRL = 4'h3;
  localparam logic [3:0] OFF_CH2_LOW = 4'h4;
  localparam logic [3:0] OFF_CH2_HIGH = 4'h5;
  localparam logic [3:0] OFF_FLAGS = 4'h6;
  localparam logic [3:0] OFF_ENABLES = 4'h7;
  // control field layout
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned DUTY_LSB = 4;
  localparam logic [7:0] CTRL_WMASK = 8'h3F;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
  // capture prescaler terminal counts
  localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST = 4'hF;
endpackage
